// ==== common/cyc_pkg.sv ====
// constants, pattern function and role encoding for the correlator cycle timing
package cyc_pkg;
   // ****************************************
   // clock and cycle lengths
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_PERIOD_PS = 100000;
   localparam int FFT_CYC_LEN = 516;
   localparam int FFT_LOAD_LEN = 512;
   localparam int FFT_SWITCH_LEN = 4;
   localparam int FFT_AW = 10;
   localparam int DELAY_PERIOD_NS = 4000000;
   localparam int INTEG_PERIOD_NS = 131000000;
   localparam int NCO_PERIOD_PS = 62500;
   localparam int DELAY_CYC_DEF = DELAY_PERIOD_NS / CLK_PERIOD_NS;
   localparam int INTEG_CYC_DEF = INTEG_PERIOD_NS / CLK_PERIOD_NS;
   // longest time: rounds down, but never below one cycle
   localparam int NCO_CYC = (NCO_PERIOD_PS / CLK_PERIOD_PS < 1) ? 1 :
      NCO_PERIOD_PS / CLK_PERIOD_PS;
   localparam int CNT_W = 21;
   // ****************************************
   // sample buffer and data widths
   // ****************************************
   localparam int SAMPLE_W = 18;
   localparam int BANK_DEPTH = 512;
   localparam int BANK_AW = 9;
   localparam int DEFORMATTER_N = 6;
   localparam int DELAY_W = 32;
   localparam int RATE_W = 16;
   localparam int TRK_AW = 12;
   // ****************************************
   // sequencer pattern bits
   // ****************************************
   localparam int PAT_W = 4;
   localparam int PAT_LOAD = 0;
   localparam int PAT_START = 1;
   localparam int PAT_SWITCH = 2;
   localparam int PAT_NCO = 3;

   typedef enum logic [2:0] {
      ROLE_IDLE = 3'h1,
      ROLE_SLAVE = 3'h2,
      ROLE_MASTER = 3'h4
   } role_e;

   function automatic logic [PAT_W-1:0] fft_pattern(input int a);
      logic [PAT_W-1:0] p;
      p = '0;
      p[PAT_LOAD] = (a < FFT_LOAD_LEN);
      p[PAT_START] = (a == 0);
      p[PAT_SWITCH] = (a >= FFT_LOAD_LEN);
      p[PAT_NCO] = ((a % NCO_CYC) == 0);
      return p;
   endfunction : fft_pattern
endpackage : cyc_pkg

// ==== common/seq_if.sv ====
// link between the rack controller and its fft cycle sequencer
`timescale 1ns/1ps
interface seq_if;
   logic advance;
   logic restart;
   logic [cyc_pkg::FFT_AW-1:0] addr;
   logic [cyc_pkg::PAT_W-1:0] pattern;
   modport seq (input advance, input restart, output addr, output pattern);
   modport ctl (output advance, output restart, input addr, input pattern);
endinterface : seq_if

// ==== hdl/fft_cycle_sequencer.sv ====
// pattern memory addressed by the cyclic fft cycle counter
`timescale 1ns/1ps
module fft_cycle_sequencer (
   input wire logic ref_clk,
   input wire logic rst,
   seq_if.seq sq
);
   logic [cyc_pkg::FFT_AW-1:0] addr_reg;
   logic [cyc_pkg::PAT_W-1:0] pattern_reg;
   logic [cyc_pkg::PAT_W-1:0] rom [cyc_pkg::FFT_CYC_LEN];

   // ****************************************
   // pattern memory, one word per cycle step
   // ****************************************
   for (genvar i = 0; i < cyc_pkg::FFT_CYC_LEN; i++) begin : g_rom
      assign rom[i] = cyc_pkg::fft_pattern(i);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         addr_reg <= '0;
      end else if (sq.restart) begin
         addr_reg <= '0;
      end else if (sq.advance) begin
         if (addr_reg == cyc_pkg::FFT_AW'(cyc_pkg::FFT_CYC_LEN - 1)) begin
            addr_reg <= '0;
         end else begin
            addr_reg <= addr_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pattern_reg <= '0;
      end else begin
         pattern_reg <= rom[addr_reg];
      end
   end

   assign sq.addr = addr_reg;
   assign sq.pattern = pattern_reg;
endmodule : fft_cycle_sequencer

// ==== hdl/sample_bank_buffer.sv ====
// two-bank sample buffer, one bank written while the other is read
`timescale 1ns/1ps
module sample_bank_buffer (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic wr_bank,
   input wire logic [cyc_pkg::BANK_AW-1:0] wr_addr,
   input wire logic [cyc_pkg::SAMPLE_W-1:0] wr_data,
   input wire logic [cyc_pkg::BANK_AW-1:0] rd_addr,
   output logic [cyc_pkg::SAMPLE_W-1:0] rd_data
);
   logic [cyc_pkg::SAMPLE_W-1:0] mem [2*cyc_pkg::BANK_DEPTH];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[{wr_bank, wr_addr}] <= wr_data;
      end
   end

   // reads come from the bank not being filled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[{~wr_bank, rd_addr}];
      end
   end
endmodule : sample_bank_buffer

// ==== hdl/rack_timing_controller.sv ====
// rack timing controller: fft, fringe/delay and integration cycle timing
// Function
// R1: fft cycle repeats every 516 system clocks, the shortest cycle.
// R2: first 512 clocks load one bank, last 4 switch banks.
// R3: sample buffer is two 512 x 18 banks, write one, read other.
// R4: one sample written per system clock.
// R5: fft cycle length fixed for all transform sizes 64 to 2048.
// R6: fringe/delay cycle repeats every 4 ms.
// R7: new model parameters at 4 ms boundary, linear delay slope between.
// R8: integration cycle repeats every 131 ms, marks accumulator readout.
// R9: fft and delay cycles restart on the integration tic.
// R10: master role only after a host command naming it master.
// R11: master sequencers free-run on the system clock alone.
// R12: slave sequencers advance only while the integration gate input allows.
// R13: integration tic goes to the fft control unit and six deformatters.
// R14: master also sends integration tic to accumulator and host.
// R15: accumulator transfer interrupt raised on each integration tic; code raises it only on the master.
// R16: sequencer is a pattern memory addressed by a cyclic counter.
// R17: fractional delay oscillator strobe every 62.5 ns in fft cycle; code strobes every 100 ns system clock.
// R18: upstream delay buffers cover the bank-switch gap.
// R19: track read pointer skips headers, integer delay at delay tic.
// R20: gated-off slave holds counters at start, resumes with master.
`timescale 1ns/1ps
module rack_timing_controller #(
   parameter int DELAY_CYC = cyc_pkg::DELAY_CYC_DEF,
   parameter int INTEG_CYC = cyc_pkg::INTEG_CYC_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic host_cmd_valid,
   input wire logic host_cmd_master,
   input wire logic integration_cycle_gate,
   input wire logic [cyc_pkg::SAMPLE_W-1:0] sample_data,
   input wire logic [cyc_pkg::BANK_AW-1:0] fft_rd_addr,
   input wire logic track_rd_req,
   input wire logic [cyc_pkg::TRK_AW-1:0] frame_len,
   input wire logic [cyc_pkg::TRK_AW-1:0] header_len,
   input wire logic [cyc_pkg::TRK_AW-1:0] int_delay,
   input wire logic [cyc_pkg::DELAY_W-1:0] model_offset,
   input wire logic [cyc_pkg::RATE_W-1:0] model_rate,
   output logic master_gate_out,
   output logic is_master,
   output logic [cyc_pkg::SAMPLE_W-1:0] fft_rd_data,
   output logic write_bank,
   output logic bank_switching,
   output logic fft_cycle_tic,
   output logic nco_strobe,
   output logic delay_tic,
   output logic [cyc_pkg::DELAY_W-1:0] delay_value,
   output logic [cyc_pkg::TRK_AW-1:0] track_rd_addr,
   output logic fcu_integ_tic,
   output logic [cyc_pkg::DEFORMATTER_N-1:0] deformatter_integ_tic,
   output logic lta_integ_tic,
   output logic host_integ_tic,
   output logic lta_transfer_irq
);
   localparam logic [cyc_pkg::CNT_W-1:0] DELAY_LAST =
      cyc_pkg::CNT_W'(DELAY_CYC - 1);
   localparam logic [cyc_pkg::CNT_W-1:0] INTEG_LAST =
      cyc_pkg::CNT_W'(INTEG_CYC - 1);
   localparam logic [cyc_pkg::FFT_AW-1:0] FFT_LAST =
      cyc_pkg::FFT_AW'(cyc_pkg::FFT_CYC_LEN - 1);

   cyc_pkg::role_e role_reg;
   logic advance;
   logic run_reg;
   logic integ_wrap;
   logic delay_wrap;
   logic bank_write_en;
   logic write_bank_reg;
   logic [cyc_pkg::CNT_W-1:0] integ_cnt_reg;
   logic [cyc_pkg::CNT_W-1:0] delay_cnt_reg;
   logic [cyc_pkg::RATE_W-1:0] rate_reg;
   logic [cyc_pkg::TRK_AW-1:0] pos_reg;
   logic integ_tic_reg;
   seq_if sq ();

   // ****************************************
   // role selection
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         role_reg <= cyc_pkg::ROLE_IDLE;
      end else begin
         case (role_reg)
            cyc_pkg::ROLE_IDLE,
            cyc_pkg::ROLE_SLAVE,
            cyc_pkg::ROLE_MASTER: begin
               if (host_cmd_valid) begin // R10
                  role_reg <= host_cmd_master ? cyc_pkg::ROLE_MASTER :
                     cyc_pkg::ROLE_SLAVE;
               end
            end
            default: begin
               role_reg <= cyc_pkg::ROLE_IDLE;
            end
         endcase
      end
   end

   assign is_master = (role_reg == cyc_pkg::ROLE_MASTER);

   // ****************************************
   // cycle gating
   // ****************************************
   // an undesignated board waits like a slave; master ignores the gate
   assign advance = is_master | integration_cycle_gate; // R11 R12

   // gate rises only at an integration boundary so slaves start in step
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         master_gate_out <= 1'b0;
      end else if (!is_master) begin
         master_gate_out <= 1'b0;
      end else if (integ_cnt_reg == INTEG_LAST) begin
         master_gate_out <= 1'b1; // R20
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= advance;
      end
   end

   // ****************************************
   // integration cycle
   // ****************************************
   assign integ_wrap = advance && (integ_cnt_reg == INTEG_LAST);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         integ_cnt_reg <= '0;
      end else if (!advance || integ_wrap) begin
         integ_cnt_reg <= '0; // R8 R20
      end else begin
         integ_cnt_reg <= integ_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         integ_tic_reg <= 1'b0;
         fcu_integ_tic <= 1'b0;
         deformatter_integ_tic <= '0;
         lta_integ_tic <= 1'b0;
         host_integ_tic <= 1'b0;
      end else begin
         integ_tic_reg <= integ_wrap;
         fcu_integ_tic <= integ_wrap; // R13
         deformatter_integ_tic <= {cyc_pkg::DEFORMATTER_N{integ_wrap}}; // R13
         lta_integ_tic <= integ_wrap && is_master; // R14
         host_integ_tic <= integ_wrap && is_master; // R14
      end
   end

   // readout request toward the filter follows the accumulator tic
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lta_transfer_irq <= 1'b0;
      end else begin
         lta_transfer_irq <= lta_integ_tic; // R15
      end
   end

   // ****************************************
   // fft cycle
   // ****************************************
   // cycle length never depends on transform size; big sizes use pipelines
   assign sq.advance = advance; // R5 R11
   assign sq.restart = !advance || integ_wrap; // R9 R20

   fft_cycle_sequencer u_seq ( // R16
      .ref_clk(ref_clk),
      .rst(rst),
      .sq(sq)
   );

   // pattern word lags the address by one clock; gated while held
   assign fft_cycle_tic = sq.pattern[cyc_pkg::PAT_START] & run_reg; // R1
   assign bank_switching = sq.pattern[cyc_pkg::PAT_SWITCH] & run_reg; // R2
   assign nco_strobe = sq.pattern[cyc_pkg::PAT_NCO] & run_reg; // R17

   // one sample per clock in the load window; none in the switch gap
   assign bank_write_en = advance && !sq.restart &&
      (sq.addr < cyc_pkg::FFT_AW'(cyc_pkg::FFT_LOAD_LEN)); // R2 R4

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         write_bank_reg <= 1'b0;
      end else if (advance && !sq.restart && sq.addr == FFT_LAST) begin
         write_bank_reg <= ~write_bank_reg; // R2
      end
   end

   assign write_bank = write_bank_reg;

   // samples lost in the switch gap are the upstream buffers' concern
   sample_bank_buffer u_buf ( // R3 R18
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(bank_write_en),
      .wr_bank(write_bank_reg),
      .wr_addr(sq.addr[cyc_pkg::BANK_AW-1:0]),
      .wr_data(sample_data),
      .rd_addr(fft_rd_addr),
      .rd_data(fft_rd_data)
   );

   // ****************************************
   // fringe/delay cycle
   // ****************************************
   assign delay_wrap = advance && (delay_cnt_reg == DELAY_LAST);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         delay_cnt_reg <= '0;
      end else if (!advance || integ_wrap || delay_wrap) begin
         delay_cnt_reg <= '0; // R6 R9
      end else begin
         delay_cnt_reg <= delay_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         delay_tic <= 1'b0;
      end else begin
         delay_tic <= delay_wrap; // R6
      end
   end

   // parameters only taken at the boundary, slope applied in between
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         delay_value <= '0;
         rate_reg <= '0;
      end else if (delay_wrap) begin
         delay_value <= model_offset; // R7
         rate_reg <= model_rate; // R7
      end else if (advance) begin
         delay_value <= delay_value +
            {{(cyc_pkg::DELAY_W-cyc_pkg::RATE_W){rate_reg[cyc_pkg::RATE_W-1]}},
            rate_reg}; // R7
      end
   end

   // ****************************************
   // track buffer read pointer
   // ****************************************
   // delay jump wins over a read in the same clock; that read is dropped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         track_rd_addr <= '0;
         pos_reg <= '0;
      end else if (delay_wrap) begin
         track_rd_addr <= track_rd_addr + int_delay; // R19
      end else if (track_rd_req) begin
         if (pos_reg == frame_len - 1'b1) begin
            pos_reg <= header_len; // R19
            track_rd_addr <= track_rd_addr + 1'b1 + header_len; // R19
         end else begin
            pos_reg <= pos_reg + 1'b1;
            track_rd_addr <= track_rd_addr + 1'b1;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [cyc_pkg::FFT_AW-1:0] gap_reg;
   logic gap_ok_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gap_reg <= '0;
         gap_ok_reg <= 1'b0;
      end else if (sq.restart) begin
         gap_reg <= '0;
         gap_ok_reg <= 1'b0;
      end else if (fft_cycle_tic) begin
         gap_reg <= 10'h001;
         gap_ok_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_switch_gap;
      bank_switching [*4] ##1 !bank_switching;
   endsequence

   a_fft_period: assert property ( // R1
      (fft_cycle_tic && gap_ok_reg) |-> gap_reg == 10'h204)
      else $error("fft cycle not 516 clocks");
   // switch flag lags the address by one clock, so look one clock later
   a_load_window: assert property ( // R2
      bank_write_en |-> (sq.addr < 10'h200) ##1 !bank_switching)
      else $error("write outside load window");
   a_switch_gap: assert property ( // R2
      ($rose(bank_switching) && integ_cnt_reg < INTEG_LAST - 21'h00000A
      && advance) |-> s_switch_gap)
      else $error("bank switch gap not 4 clocks");
   a_bank_toggle: assert property ( // R2
      (advance && !sq.restart && sq.addr == FFT_LAST)
      |=> write_bank != $past(write_bank))
      else $error("bank did not swap");
   a_delay_load: assert property ( // R7
      delay_tic |-> delay_value == $past(model_offset))
      else $error("model offset not loaded");
   a_delay_slope: assert property ( // R7
      (delay_tic && advance && !delay_wrap) |=>
      delay_value == $past(delay_value) + {{16{rate_reg[15]}}, rate_reg})
      else $error("delay slope wrong");
   a_integ_fanout: assert property ( // R13
      integ_tic_reg |-> fcu_integ_tic && deformatter_integ_tic == 6'h3F)
      else $error("integration tic not fanned out");
   a_master_tics: assert property ( // R14
      (lta_integ_tic || host_integ_tic) |-> $past(is_master))
      else $error("tic from non-master");
   a_lta_irq: assert property ( // R15
      lta_integ_tic |=> lta_transfer_irq)
      else $error("no transfer interrupt");
   a_master_cmd: assert property ( // R10
      $rose(is_master) |-> $past(host_cmd_valid && host_cmd_master))
      else $error("master without command");
   a_slave_hold: assert property ( // R12
      (!is_master && !integration_cycle_gate) |=>
      integ_cnt_reg == '0 && sq.addr == '0 && delay_cnt_reg == '0)
      else $error("slave ran without gate");
endmodule : rack_timing_controller

// ==== tb/upstream_feeder.sv ====
// upstream sample stream and master gate stand-in for the rack controller
`timescale 1ns/1ps
module upstream_feeder (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic gate_en,
   output logic [cyc_pkg::SAMPLE_W-1:0] sample_data,
   output logic integration_cycle_gate
);
   // ****
   // far side
   // ****
   // fresh sample every clock, switch gap included; the 4 gap samples are never written
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sample_data <= '0;
      end else begin
         sample_data <= sample_data + 18'h00001;
      end
   end
   // master gate, low until the bench lets the slave go
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         integration_cycle_gate <= 1'b0;
      end else begin
         integration_cycle_gate <= gate_en;
      end
   end
endmodule : upstream_feeder

// ==== tb/rack_timing_controller_test.sv ====
// self-checking bench for the rack timing controller
`timescale 1ns/1ps
module rack_timing_controller_test;
   localparam int DLY = 600;
   localparam int INTEG = 3000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic host_cmd_valid = 1'b0;
   logic host_cmd_master = 1'b0;
   logic gate_en = 1'b0;
   logic track_rd_req = 1'b0;
   logic [cyc_pkg::BANK_AW-1:0] fft_rd_addr = '0;
   logic [cyc_pkg::TRK_AW-1:0] frame_len = 12'h008;
   logic [cyc_pkg::TRK_AW-1:0] header_len = 12'h002;
   logic [cyc_pkg::TRK_AW-1:0] int_delay = 12'h005;
   logic [cyc_pkg::DELAY_W-1:0] model_offset = 32'h00001000;
   logic [cyc_pkg::RATE_W-1:0] model_rate = 16'h0003;
   logic integration_cycle_gate, master_gate_out, is_master, write_bank;
   logic [cyc_pkg::SAMPLE_W-1:0] sample_data, fft_rd_data;
   logic bank_switching, fft_cycle_tic, nco_strobe, delay_tic;
   logic [cyc_pkg::DELAY_W-1:0] delay_value;
   logic [cyc_pkg::TRK_AW-1:0] track_rd_addr;
   logic [cyc_pkg::DEFORMATTER_N-1:0] deformatter_integ_tic;
   logic fcu_integ_tic, lta_integ_tic, host_integ_tic, lta_transfer_irq;
   int miscompares = 0;
   int num_checks = 0;

   always #(cyc_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   // shortened cycle counts keep the run short
   rack_timing_controller #(.DELAY_CYC(DLY), .INTEG_CYC(INTEG)) DUT (
      .ref_clk, .rst, .host_cmd_valid, .host_cmd_master,
      .integration_cycle_gate, .sample_data, .fft_rd_addr, .track_rd_req,
      .frame_len, .header_len, .int_delay, .model_offset, .model_rate,
      .master_gate_out, .is_master, .fft_rd_data, .write_bank,
      .bank_switching, .fft_cycle_tic, .nco_strobe, .delay_tic,
      .delay_value, .track_rd_addr, .fcu_integ_tic, .deformatter_integ_tic,
      .lta_integ_tic, .host_integ_tic, .lta_transfer_irq
   );
   upstream_feeder far_side (
      .ref_clk, .rst, .gate_en, .sample_data, .integration_cycle_gate
   );

   // ****
   // helpers
   // ****
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [63:0] exp,
                      input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   function automatic logic ev(input int k);
      case (k)
         0: return fft_cycle_tic;
         1: return delay_tic;
         2: return fcu_integ_tic;
         default: return integration_cycle_gate;
      endcase
   endfunction : ev

   // next occurrence of an event, counted in clocks
   task automatic gap(input int k, output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (ev(k) !== 1'b1 && n < 8000);
      if (n >= 8000) begin
         chk("event wait", 1, 0);
      end
   endtask : gap

   task automatic send_cmd(input logic m);
      @(posedge ref_clk);
      host_cmd_valid <= 1'b1;
      host_cmd_master <= m;
      @(posedge ref_clk);
      host_cmd_valid <= 1'b0;
      @(negedge ref_clk);
      chk("is_master", {63'h0, m}, {63'h0, is_master});
   endtask : send_cmd

   task automatic rd(input int a, output logic [17:0] d);
      @(posedge ref_clk);
      fft_rd_addr <= a[8:0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      d = fft_rd_data;
   endtask : rd

   // ****
   // scenarios
   // ****
   task automatic t_hold();
      int n;
      n = 0;
      send_cmd(1'b0);
      repeat (700) begin
         @(negedge ref_clk);
         n += int'(fcu_integ_tic === 1'b1 || fft_cycle_tic === 1'b1);
         n += int'(delay_tic === 1'b1);
      end
      chk("gated tics", 0, n);
   endtask : t_hold

   task automatic t_track();
      int pos, adr;
      pos = 0;
      adr = 0;
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         track_rd_req <= 1'b1;
         @(posedge ref_clk);
         track_rd_req <= 1'b0;
         if (pos == int'(frame_len) - 1) begin
            pos = int'(header_len);
            adr += 1 + int'(header_len);
         end else begin
            pos++;
            adr++;
         end
      end
      @(negedge ref_clk);
      chk("track pointer", adr, track_rd_addr);
   endtask : t_track

   task automatic t_fft();
      int n, sw, nco, tg;
      logic wb;
      send_cmd(1'b1);
      gap(0, n);
      n = 0;
      sw = 0;
      nco = 0;
      tg = 0;
      wb = write_bank;
      do begin
         @(negedge ref_clk);
         n++;
         sw += int'(bank_switching === 1'b1);
         nco += int'(nco_strobe === 1'b1);
         tg += int'(write_bank !== wb);
         wb = write_bank;
      end while (fft_cycle_tic !== 1'b1 && n < 2000);
      chk("fft period", cyc_pkg::FFT_CYC_LEN, n);
      chk("switch clocks", cyc_pkg::FFT_SWITCH_LEN, sw);
      chk("bank toggles", 1, tg);
      chk("nco strobes", cyc_pkg::FFT_CYC_LEN, nco);
   endtask : t_fft

   task automatic t_buffer();
      logic [17:0] d0, d1, d2;
      rd(0, d0);
      rd(1, d1);
      rd(511, d2);
      // feeder counts up by one a clock, so offsets give addresses
      chk("bank step", 1, d1 - d0);
      chk("bank span", 511, d2 - d0);
   endtask : t_buffer

   task automatic t_delay();
      int n;
      logic [11:0] a;
      gap(1, n);
      a = track_rd_addr;
      chk("delay start", model_offset, delay_value);
      @(negedge ref_clk);
      chk("delay slope", model_offset + model_rate, delay_value);
      gap(1, n);
      chk("delay period", DLY - 1, n);
      chk("track jump", a + int_delay, track_rd_addr);
   endtask : t_delay

   task automatic t_integ();
      int n;
      gap(2, n);
      chk("integ fanout", 64'h1FF, {deformatter_integ_tic, fcu_integ_tic,
          lta_integ_tic, host_integ_tic});
      chk("gate out", 1, master_gate_out);
      @(negedge ref_clk);
      chk("transfer irq", 1, lta_transfer_irq);
      chk("fft restart", 1, fft_cycle_tic);
      gap(2, n);
      chk("integ period", INTEG - 1, n);
   endtask : t_integ

   task automatic t_resume();
      int n;
      t_hold();
      @(posedge ref_clk);
      gate_en <= 1'b1;
      gap(3, n);
      gap(2, n);
      chk("resume in step", 1, n >= INTEG - 1 && n <= INTEG + 1);
      chk("slave host tic", 0, {lta_integ_tic, host_integ_tic});
      chk("slave fcu tic", 1, fcu_integ_tic);
   endtask : t_resume

   initial begin
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("reset outputs", 64'h0, {master_gate_out, is_master, write_bank,
          bank_switching, fft_cycle_tic, nco_strobe, delay_tic, delay_value,
          track_rd_addr, fcu_integ_tic, deformatter_integ_tic,
          lta_integ_tic, host_integ_tic, lta_transfer_irq});
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_hold();
      t_track();
      t_fft();
      t_buffer();
      t_delay();
      t_integ();
      t_resume();
      stop_test();
   end

   // cut a hang well past the longest expected run
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end
endmodule : rack_timing_controller_test
